// ==== rtl/gpp_pkg.sv ====
// Package for the general purpose pin port: register map and reset values.
// Assumes one system clock and a host control port decoding byte addresses.
package gpp_pkg;
	localparam int         GPP_NUM_PINS    = 7;
	localparam int         GPP_NUM_IRQ     = 4;
	localparam int         GPP_ADDR_W      = 8;
	localparam int         GPP_DATA_W      = 8;
	localparam logic [7:0] GPP_OFS_DIR     = 8'h2c;
	localparam logic [7:0] GPP_OFS_POL     = 8'h2d;
	localparam logic [7:0] GPP_OFS_TRIG    = 8'h2e;
	localparam logic [7:0] GPP_OFS_STATE   = 8'h2f;
	localparam logic [7:0] GPP_OFS_UNMASK  = 8'h30;
	localparam logic [7:0] GPP_OFS_CHIPIRQ = 8'h2a;
	localparam logic [6:0] GPP_RST_DIR     = 7'h00;
	localparam logic [6:0] GPP_RST_POL     = 7'h7f;
	localparam logic [6:0] GPP_RST_TRIG    = 7'h00;
	localparam logic [3:0] GPP_RST_UNMASK  = 4'h0;
	localparam int         GPP_SYNC_STAGES = 3;
endpackage : gpp_pkg

// ==== rtl/gpp_sync.sv ====
// Three-stage input synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/1ns
module gpp_sync
	import gpp_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	// Pin and filtered level
	input  wire logic pin_i,
	output logic      level_o
);
	logic [GPP_SYNC_STAGES-1:0] stage;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			stage <= '0;
		end else begin
			stage <= {stage[GPP_SYNC_STAGES-2:0], pin_i};
		end
	end

	// Change counts once second and third stage agree
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			level_o <= 1'b0;
		end else if (stage[1] == stage[2]) begin
			level_o <= stage[2];
		end
	end
endmodule : gpp_sync

// ==== rtl/gpp_port.sv ====
// General purpose pin port with per-pin direction, polarity and trigger
// registers, and an interrupt unmask register for pins 0 to 3 only. Assumes a host control port that gives a
// one-cycle read or write strobe with byte address; read data is registered.
`timescale 1ns/1ns
module gpp_port
	import gpp_pkg::*;
#(
	parameter int NUM_PINS = GPP_NUM_PINS,
	parameter int NUM_IRQ  = GPP_NUM_IRQ
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  sys_rst_i,
	// Host control port
	input  wire logic [GPP_ADDR_W-1:0] host_addr_i,
	input  wire logic                  host_wr_i,
	input  wire logic                  host_rd_i,
	input  wire logic [GPP_DATA_W-1:0] host_wdata_i,
	output logic      [GPP_DATA_W-1:0] host_rdata_o,
	// Pins
	input  wire logic [NUM_PINS-1:0]   pin_i,
	output logic      [NUM_PINS-1:0]   pin_o,
	output logic      [NUM_PINS-1:0]   pin_oe_o,
	// Summary to chip interrupt logic
	output logic                       pin_irq_o
);
	logic [NUM_PINS-1:0] pin_direction_bit;
	logic [NUM_PINS-1:0] pin_polarity_type_bit;
	logic [NUM_PINS-1:0] pin_trigger_select_bit;
	logic [NUM_PINS-1:0] pin_state_bit;
	logic [NUM_PINS-1:0] out_level;
	logic [NUM_IRQ-1:0]  pin_irq_unmask_bit;
	logic [NUM_PINS-1:0] pin_sync;
	logic [NUM_PINS-1:0] active_now;
	logic [NUM_PINS-1:0] active_prev;
	logic [NUM_PINS-1:0] edge_seen;
	logic [NUM_PINS-1:0] next_state;
	logic                state_rd;
	logic                next_irq;

	function automatic logic hit(input logic [GPP_ADDR_W-1:0] ofs);
		return host_addr_i == ofs;
	endfunction : hit

	// Pin synchronisers
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_sync
			gpp_sync u_sync (
				.clk_i     (clk_i),
				.sys_rst_i (sys_rst_i),
				.pin_i     (pin_i[g]),
				.level_o   (pin_sync[g])
			);
		end
	endgenerate

	// Active level per pin from polarity
	assign active_now = ~(pin_sync ^ pin_polarity_type_bit);
	assign edge_seen  = active_now & ~active_prev;
	// Chip interrupt status read does not qualify here
	assign state_rd   = host_rd_i && hit(GPP_OFS_STATE);

	// Configuration registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_direction_bit      <= GPP_RST_DIR;
			pin_polarity_type_bit  <= GPP_RST_POL;
			pin_trigger_select_bit <= GPP_RST_TRIG;
			pin_irq_unmask_bit     <= GPP_RST_UNMASK;
		end else if (host_wr_i) begin
			if (hit(GPP_OFS_DIR))
				pin_direction_bit <= host_wdata_i[NUM_PINS-1:0];
			if (hit(GPP_OFS_POL))
				pin_polarity_type_bit <= host_wdata_i[NUM_PINS-1:0];
			if (hit(GPP_OFS_TRIG))
				pin_trigger_select_bit <= host_wdata_i[NUM_PINS-1:0];
			if (hit(GPP_OFS_UNMASK))
				pin_irq_unmask_bit <= host_wdata_i[NUM_IRQ-1:0];
		end
	end

	// Output level latch written through the status register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			out_level <= '0;
		end else if (host_wr_i && hit(GPP_OFS_STATE)) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				if (pin_direction_bit[i])
					out_level[i] <= host_wdata_i[i];
			end
		end
	end

	// Previous active level for edge detection
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			active_prev <= '0;
		end else begin
			active_prev <= active_now;
		end
	end

	// Status capture; mask takes no part
	always_comb begin
		next_state = pin_state_bit;
		for (int i = 0; i < NUM_PINS; i++) begin
			if (pin_direction_bit[i]) begin
				next_state[i] = out_level[i];
			end else if (!pin_trigger_select_bit[i]) begin
				next_state[i] = active_now[i];
			end else begin
				if (state_rd)
					next_state[i] = 1'b0;
				if (edge_seen[i])
					next_state[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_state_bit <= '0;
		end else begin
			pin_state_bit <= next_state;
		end
	end

	// Summary interrupt from unmasked input pins
	always_comb begin
		next_irq = 1'b0;
		for (int i = 0; i < NUM_IRQ; i++) begin
			if (!pin_direction_bit[i] && pin_irq_unmask_bit[i])
				next_irq = next_irq | next_state[i];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_irq_o <= 1'b0;
		end else begin
			pin_irq_o <= next_irq;
		end
	end

	// Pin drivers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_o    <= '0;
			pin_oe_o <= '0;
		end else begin
			for (int i = 0; i < NUM_PINS; i++) begin
				if (pin_polarity_type_bit[i]) begin
					pin_o[i]    <= 1'b0;
					pin_oe_o[i] <= pin_direction_bit[i] & ~out_level[i];
				end else begin
					pin_o[i]    <= out_level[i];
					pin_oe_o[i] <= pin_direction_bit[i];
				end
			end
		end
	end

	// Register read data
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			host_rdata_o <= '0;
		end else if (host_rd_i) begin
			host_rdata_o <= '0;
			unique case (1'b1)
				hit(GPP_OFS_DIR):
					host_rdata_o[NUM_PINS-1:0] <= pin_direction_bit;
				hit(GPP_OFS_POL):
					host_rdata_o[NUM_PINS-1:0] <= pin_polarity_type_bit;
				hit(GPP_OFS_TRIG):
					host_rdata_o[NUM_PINS-1:0] <= pin_trigger_select_bit;
				hit(GPP_OFS_STATE):
					host_rdata_o[NUM_PINS-1:0] <= pin_state_bit;
				hit(GPP_OFS_UNMASK):
					host_rdata_o[NUM_IRQ-1:0] <= pin_irq_unmask_bit;
				default:
					host_rdata_o <= '0;
			endcase
		end
	end

	// Assertions
	a_reset_dir_in: assert property (@(posedge clk_i)
		$past(sys_rst_i) |-> pin_oe_o == '0)
		else $error("Pins not inputs after reset");

	a_edge_sets_bit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(!pin_direction_bit[0] && pin_trigger_select_bit[0]
		 && edge_seen[0]) |=> pin_state_bit[0])
		else $error("Edge did not set status bit");

	a_read_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_rd && !pin_direction_bit[1]
		 && pin_trigger_select_bit[1] && !edge_seen[1]) |=> !pin_state_bit[1])
		else $error("Status read did not clear edge bit");

	a_level_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(!pin_direction_bit[2] && !pin_trigger_select_bit[2])
		|=> pin_state_bit[2] == $past(active_now[2]))
		else $error("Level status not following pin");

	a_chip_rd_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(host_rd_i && host_addr_i == GPP_OFS_CHIPIRQ
		 && pin_trigger_select_bit[0] && !pin_direction_bit[0] && !edge_seen[0])
		|=> pin_state_bit[0] == $past(pin_state_bit[0]))
		else $error("Chip status read changed pin status");

	a_irq_or: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		pin_irq_o == |(pin_state_bit[NUM_IRQ-1:0]
		& $past(pin_irq_unmask_bit)
		& ~$past(pin_direction_bit[NUM_IRQ-1:0])))
		else $error("Summary flag not OR of unmasked bits");

	a_irq_high_pins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(pin_irq_unmask_bit == '0) |=> !pin_irq_o)
		else $error("Masked pins raised summary");

	a_input_ro: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(host_wr_i && hit(GPP_OFS_STATE) && !pin_direction_bit[3])
		|=> out_level[3] == $past(out_level[3]))
		else $error("Write changed input pin status");

	a_out_drive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(pin_direction_bit[4] && !pin_polarity_type_bit[4]) [*2]
		|-> pin_o[4] == $past(out_level[4]) && pin_oe_o[4])
		else $error("Push-pull output level wrong");

	a_open_drain: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$past(pin_polarity_type_bit[5] && pin_direction_bit[5])
		|-> !pin_o[5] && pin_oe_o[5] == !$past(out_level[5]))
		else $error("Open-drain drove high");

	// Multi-step behaviour
	sequence s_edge_armed;
		!pin_direction_bit[1] && pin_trigger_select_bit[1]
		&& pin_irq_unmask_bit[1] && pin_state_bit[1];
	endsequence

	sequence s_quiet_read;
		state_rd && !edge_seen[1];
	endsequence

	sequence s_level_active;
		!pin_direction_bit[0] && !pin_trigger_select_bit[0]
		&& pin_irq_unmask_bit[0] && active_now[0];
	endsequence

	a_set_wins: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(state_rd && !pin_direction_bit[1] && pin_trigger_select_bit[1]
		 && edge_seen[1]) |=> pin_state_bit[1])
		else $error("Read beat a new edge");

	a_unmask_rd_clr: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(s_edge_armed ##0 s_quiet_read) |=> !pin_state_bit[1])
		else $error("Unmasked edge read kept status bit");

	a_mask_level: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(!pin_direction_bit[3] && !pin_trigger_select_bit[3])
		|=> pin_state_bit[3] == $past(active_now[3]))
		else $error("Mask changed level status");

	a_out_status: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		pin_direction_bit[4]
		|=> pin_state_bit[4] == $past(out_level[4]))
		else $error("Output status not written level");

	a_trig_ignored: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(pin_direction_bit[5] && pin_trigger_select_bit[5])
		|=> pin_state_bit[5] == $past(out_level[5]))
		else $error("Trigger bit acted on output pin");

	a_rdata_status: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		state_rd
		|=> host_rdata_o[NUM_PINS-1:0] == $past(pin_state_bit))
		else $error("Status read data wrong");

	a_dir_reset: assert property (
		@(posedge clk_i)
		$past(sys_rst_i)
		|-> pin_direction_bit == GPP_RST_DIR)
		else $error("Direction not reset");

	a_pol_reset: assert property (
		@(posedge clk_i)
		$past(sys_rst_i)
		|-> pin_polarity_type_bit == GPP_RST_POL)
		else $error("Polarity not reset");

	a_state_reset: assert property (
		@(posedge clk_i)
		$past(sys_rst_i)
		|-> pin_state_bit == '0 && pin_trigger_select_bit == GPP_RST_TRIG)
		else $error("Status or trigger not reset");

	a_unmask_reset: assert property (
		@(posedge clk_i)
		$past(sys_rst_i)
		|-> pin_irq_unmask_bit == GPP_RST_UNMASK && !pin_irq_o)
		else $error("Unmask or summary not reset");

	a_level_irq: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		s_level_active
		|=> pin_irq_o)
		else $error("Level input dropped summary");

	a_out_no_irq: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(pin_direction_bit[NUM_IRQ-1:0] == '1)
		|=> !pin_irq_o)
		else $error("Output pins raised summary");

	a_pp_drive: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		$past(pin_direction_bit[6] && !pin_polarity_type_bit[6])
		|-> pin_oe_o[6] && pin_o[6] == $past(out_level[6]))
		else $error("Push-pull drive wrong");

	a_chip_rd_zero: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(host_rd_i && host_addr_i == GPP_OFS_CHIPIRQ)
		|=> host_rdata_o == '0)
		else $error("Chip status address read not zero");
endmodule : gpp_port

// ==== tb/gpp_pin_model.sv ====
// Board model around the pins: pull-up and an external driver.
// Assumes the port's drive and enable are presented every cycle.
`timescale 1ns/1ns
module gpp_pin_model
	import gpp_pkg::*;
(
	// Port drive
	input  wire logic [GPP_NUM_PINS-1:0] port_val_i,
	input  wire logic [GPP_NUM_PINS-1:0] port_oe_i,
	// External driver
	input  wire logic [GPP_NUM_PINS-1:0] ext_en_i,
	input  wire logic [GPP_NUM_PINS-1:0] ext_val_i,
	// Wire level
	output logic      [GPP_NUM_PINS-1:0] level_o
);
	// Port drive, else external drive, else pull-up
	always_comb begin
		for (int i = 0; i < GPP_NUM_PINS; i++) begin
			if (port_oe_i[i])
				level_o[i] = port_val_i[i];
			else if (ext_en_i[i])
				level_o[i] = ext_val_i[i];
			else
				level_o[i] = 1'b1;
		end
	end
endmodule : gpp_pin_model

// ==== tb/gpp_port_tb.sv ====
// Self-checking bench for the pin port.
// Assumes the pin model closes the loop from pin_o to pin_i.
`timescale 1ns/1ns
module gpp_port_tb
	import gpp_pkg::*;
;
	logic       clk_i = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [6:0] lvl;
	logic [6:0] pin_o;
	logic [6:0] oe;
	logic       irq;
	logic [6:0] ext_en = 7'h7f;
	logic [6:0] ext_val = 7'h00;
	int         fail_count = 0;
	int         samples_checked = 0;
	int         cyc = 0;
	gpp_port i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.host_addr_i(addr), .host_wr_i(wr), .host_rd_i(rd),
		.host_wdata_i(wdata), .host_rdata_o(rdata), .pin_i(lvl),
		.pin_o(pin_o), .pin_oe_o(oe), .pin_irq_o(irq));
	gpp_pin_model i_pins (.port_val_i(pin_o), .port_oe_i(oe),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(lvl));
	always #5 clk_i = ~clk_i;
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count = fail_count + 1;
			finish_test();
		end
	end
	task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR t=%0t reg exp %h got %h", $time, e, g);
		end
	endtask : chk_reg
	task automatic chk_pin(input logic [6:0] e, input logic [6:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR t=%0t pin exp %h got %h", $time, e, g);
		end
	endtask : chk_pin
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		@(posedge clk_i);
		chk_reg(e, rdata);
	endtask : rd_reg
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wt
	task automatic t_reset;
		rd_reg(GPP_OFS_DIR, 8'h00);
		rd_reg(GPP_OFS_POL, 8'h7f);
		rd_reg(GPP_OFS_TRIG, 8'h00);
		rd_reg(GPP_OFS_UNMASK, 8'h00);
		rd_reg(8'h31, 8'h00);
		wr_reg(GPP_OFS_STATE, 8'h7f);
		rd_reg(GPP_OFS_STATE, 8'h00);
	endtask : t_reset
	task automatic t_level;
		ext_val <= 7'h01;
		wt(8);
		rd_reg(GPP_OFS_STATE, 8'h01);
		rd_reg(GPP_OFS_STATE, 8'h01);
		chk_pin(7'h00, {6'h00, irq});
		wr_reg(GPP_OFS_UNMASK, 8'h01);
		wt(3);
		chk_pin(7'h01, {6'h00, irq});
		rd_reg(GPP_OFS_STATE, 8'h01);
		chk_pin(7'h01, {6'h00, irq});
		ext_val <= 7'h00;
		wt(8);
		chk_pin(7'h00, {6'h00, irq});
		rd_reg(GPP_OFS_STATE, 8'h00);
	endtask : t_level
	task automatic t_edge;
		wr_reg(GPP_OFS_TRIG, 8'h02);
		wr_reg(GPP_OFS_UNMASK, 8'h00);
		ext_val <= 7'h02;
		wt(8);
		ext_val <= 7'h00;
		wt(8);
		rd_reg(GPP_OFS_STATE, 8'h02);
		rd_reg(GPP_OFS_STATE, 8'h00);
		wr_reg(GPP_OFS_UNMASK, 8'h02);
		ext_val <= 7'h02;
		wt(8);
		chk_pin(7'h01, {6'h00, irq});
		rd_reg(GPP_OFS_CHIPIRQ, 8'h00);
		chk_pin(7'h01, {6'h00, irq});
		rd_reg(GPP_OFS_STATE, 8'h02);
		wt(2);
		chk_pin(7'h00, {6'h00, irq});
		rd_reg(GPP_OFS_STATE, 8'h00);
	endtask : t_edge
	task automatic t_output;
		ext_en <= 7'h6f;
		wr_reg(GPP_OFS_DIR, 8'h10);
		wr_reg(GPP_OFS_POL, 8'h6f);
		wr_reg(GPP_OFS_STATE, 8'h10);
		wt(3);
		chk_pin(7'h10, pin_o & 7'h10);
		chk_pin(7'h10, oe & 7'h10);
		rd_reg(GPP_OFS_STATE, 8'h10);
		wr_reg(GPP_OFS_STATE, 8'h00);
		wt(3);
		chk_pin(7'h00, pin_o & 7'h10);
		wr_reg(GPP_OFS_POL, 8'h7f);
		wr_reg(GPP_OFS_STATE, 8'h10);
		wt(3);
		chk_pin(7'h00, oe & 7'h10);
		chk_pin(7'h10, lvl & 7'h10);
		wr_reg(GPP_OFS_STATE, 8'h00);
		wt(3);
		chk_pin(7'h10, oe & 7'h10);
		chk_pin(7'h00, pin_o & 7'h10);
		wr_reg(GPP_OFS_UNMASK, 8'hff);
		rd_reg(GPP_OFS_UNMASK, 8'h0f);
	endtask : t_output
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_level();
		t_edge();
		t_output();
		finish_test();
	end
endmodule : gpp_port_tb
